// ---- rtl/mct_conn_test.sv ----
// connectivity test logic: pin patterns xor-combined onto data and strobe pins
`timescale 1ns/1ps

module mct_conn_test
  import mct_pkg::*;
#(
  parameter int WIDTH      = MCT_WIDTH_X16,
  parameter bit CT_SUPPORT = 1'b1
)(
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // mode pins
  input  wire logic              i_test_enable_pin,
  input  wire logic              i_cs_n,
  input  wire logic              i_reset_pin_n,
  // address and bank test inputs
  input  wire logic [13:0]       i_addr,
  input  wire logic              i_a10_ap,
  input  wire logic              i_a12_bc,
  input  wire logic              i_we_n_a14,
  input  wire logic              i_cas_n_a15,
  input  wire logic              i_ras_n_a16,
  input  wire logic [1:0]        i_ba,
  input  wire logic [1:0]        i_bg,
  // command, clock and misc test inputs
  input  wire logic              i_act_n,
  input  wire logic              i_cke,
  input  wire logic              i_odt,
  input  wire logic              i_par,
  input  wire logic              i_ck_t,
  input  wire logic              i_ck_c,
  input  wire logic              i_alert_n,
  input  wire logic              i_dm_lower_n,
  input  wire logic              i_dm_upper_n,
  // test outputs
  output logic [WIDTH-1:0]       o_dq,
  output logic [WIDTH-1:0]       o_dq_oe,
  output logic [1:0]             o_dqs_t,
  output logic [1:0]             o_dqs_c,
  output logic [1:0]             o_dqs_oe,
  // mode status
  output logic                   o_continuity_check_mode,
  output logic                   o_vref_half_sel,
  output logic                   o_refresh_block
);

  // ************************************************************
  // test input bundle
  // ************************************************************
  typedef struct packed {
    logic        test_enable;
    logic        cs_n;
    logic        reset_n;
    logic [13:0] addr;
    logic        a10_ap;
    logic        a12_bc;
    logic        we_n_a14;
    logic        cas_n_a15;
    logic        ras_n_a16;
    logic [1:0]  ba;
    logic [1:0]  bg;
    logic        act_n;
    logic        cke;
    logic        odt;
    logic        par;
    logic        ck_t;
    logic        ck_c;
    logic        alert_n;
    logic        dm_lower_n;
    logic        dm_upper_n;
  } mct_pins_s;

  localparam int PIN_BITS = $bits(mct_pins_s);

  mct_pins_s pin_raw;
  mct_pins_s pin_acc;

  // every pin, clock pins included, is a plain test input here
  always_comb
  begin
    pin_raw.test_enable = i_test_enable_pin;
    pin_raw.cs_n        = i_cs_n;
    pin_raw.reset_n     = i_reset_pin_n;
    pin_raw.addr        = i_addr;
    pin_raw.a10_ap      = i_a10_ap;
    pin_raw.a12_bc      = i_a12_bc;
    pin_raw.we_n_a14    = i_we_n_a14;
    pin_raw.cas_n_a15   = i_cas_n_a15;
    pin_raw.ras_n_a16   = i_ras_n_a16;
    pin_raw.ba          = i_ba;
    pin_raw.bg          = i_bg;
    pin_raw.act_n       = i_act_n;
    pin_raw.cke         = i_cke;
    pin_raw.odt         = i_odt;
    pin_raw.par         = i_par;
    pin_raw.ck_t        = i_ck_t;
    pin_raw.ck_c        = i_ck_c;
    pin_raw.alert_n     = i_alert_n;
    pin_raw.dm_lower_n  = i_dm_lower_n;
    pin_raw.dm_upper_n  = i_dm_upper_n;
  end

  // ************************************************************
  // pin filters: three flops, a change counts once stages two and three agree
  // ************************************************************
  logic [PIN_BITS-1:0] acc_vec;

  generate
    genvar p;
    for (p = 0; p < PIN_BITS; p++)
    begin : g_pin
      logic sync1_reg;
      logic sync2_reg;
      logic sync3_reg;
      logic acc_bit_reg;

      always_ff @(posedge i_clk)
      begin
        sync1_reg <= pin_raw[p];
        sync2_reg <= sync1_reg;
        sync3_reg <= sync2_reg;
      end

      always_ff @(posedge i_clk)
      begin
        if (!i_rst_n)
        begin
          acc_bit_reg <= MCT_RST_PIN;
        end
        else if (sync2_reg == sync3_reg)
        begin
          acc_bit_reg <= sync3_reg;
        end
      end

      assign acc_vec[p] = acc_bit_reg;
    end
  endgenerate

  assign pin_acc = acc_vec;

  // ************************************************************
  // mode decode
  // ************************************************************
  logic mode_on;
  assign mode_on = CT_SUPPORT && pin_acc.test_enable;

  // ************************************************************
  // minterms
  // ************************************************************
  logic [MCT_NUM_MINTERMS-1:0] mt;
  logic                        mt7_mask;
  logic                        mt9_gate;

  assign mt9_gate = pin_acc.reset_n & pin_acc.test_enable;

  always_comb
  begin
    if (WIDTH == MCT_WIDTH_X16)
    begin
      mt7_mask = pin_acc.dm_upper_n ^ pin_acc.dm_lower_n;
    end
    else if (WIDTH == MCT_WIDTH_X8)
    begin
      mt7_mask = pin_acc.bg[1] ^ pin_acc.dm_lower_n;
    end
    else
    begin
      mt7_mask = pin_acc.bg[1];
    end
  end

  always_comb
  begin
    mt[0] = pin_acc.addr[1] ^ pin_acc.addr[6] ^ pin_acc.par;
    mt[1] = pin_acc.addr[8] ^ pin_acc.alert_n ^ pin_acc.addr[9];
    mt[2] = pin_acc.addr[2] ^ pin_acc.addr[5] ^ pin_acc.addr[13];
    mt[3] = pin_acc.addr[0] ^ pin_acc.addr[7] ^ pin_acc.addr[11];
    mt[4] = pin_acc.ck_c ^ pin_acc.odt ^ pin_acc.cas_n_a15;
    mt[5] = pin_acc.cke ^ pin_acc.ras_n_a16 ^ pin_acc.a10_ap;
    mt[6] = pin_acc.act_n ^ pin_acc.addr[4] ^ pin_acc.ba[1];
    mt[7] = mt7_mask ^ pin_acc.ck_t;
    mt[8] = pin_acc.we_n_a14 ^ pin_acc.a12_bc ^ pin_acc.ba[0];
    mt[9] = pin_acc.bg[0] ^ pin_acc.addr[3] ^ mt9_gate;
  end

  // ************************************************************
  // output equations
  // ************************************************************
  logic [WIDTH-1:0] dq_val;
  logic [1:0]       dqs_t_val;
  logic [1:0]       dqs_c_val;

  generate
    genvar g;
    for (g = 0; g < WIDTH; g++)
    begin : g_dq
      if (WIDTH == MCT_WIDTH_X4)
      begin : g_x4
        assign dq_val[g] = mt[2*g] ^ mt[2*g+1];
      end
      else if (g < 8)
      begin : g_lo
        assign dq_val[g] = mt[g];
      end
      else
      begin : g_hi
        assign dq_val[g] = ~mt[g-8];
      end
    end
  endgenerate

  always_comb
  begin
    dqs_t_val = {mt[9], mt[8]};
    dqs_c_val = ~dqs_t_val;
  end

  // ************************************************************
  // output stage, one flop behind the accepted pin values
  // ************************************************************
  logic drive;
  assign drive = mode_on && !pin_acc.cs_n;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_dq <= {WIDTH{MCT_RST_DRIVE}};
    end
    else
    begin
      o_dq <= dq_val;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_dqs_t <= {2{MCT_RST_DRIVE}};
    end
    else
    begin
      o_dqs_t <= dqs_t_val;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_dqs_c <= {2{MCT_RST_DRIVE}};
    end
    else
    begin
      o_dqs_c <= dqs_c_val;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_dq_oe <= {WIDTH{MCT_RST_DRIVE}};
    end
    else
    begin
      o_dq_oe <= {WIDTH{drive}};
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_dqs_oe <= {2{MCT_RST_DRIVE}};
    end
    else
    begin
      o_dqs_oe <= {2{drive}};
    end
  end

  // ************************************************************
  // mode status flags
  // ************************************************************
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_continuity_check_mode <= MCT_RST_MODE;
    end
    else
    begin
      o_continuity_check_mode <= mode_on;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_vref_half_sel <= MCT_RST_MODE;
    end
    else
    begin
      o_vref_half_sel <= mode_on ? MCT_VREF_HALF_SEL : 1'h0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_refresh_block <= MCT_RST_MODE;
    end
    else
    begin
      o_refresh_block <= mode_on;
    end
  end

endmodule // mct_conn_test

// ---- rtl/mct_pkg.sv ----
// package of constants for the memory connectivity test logic
package mct_pkg;

  // device width options
  localparam int MCT_WIDTH_X4  = 4;
  localparam int MCT_WIDTH_X8  = 8;
  localparam int MCT_WIDTH_X16 = 16;

  // number of minterms
  localparam int MCT_NUM_MINTERMS = 10;

  // reset values
  localparam logic MCT_RST_DRIVE = 1'h0;
  localparam logic MCT_RST_MODE  = 1'h0;
  localparam logic MCT_RST_PIN   = 1'h0;

  // output-valid delay in ns and its cycle count at 100 MHz (rounded down, at least one)
  localparam int MCT_CLK_PERIOD_PS        = 10000;
  localparam int MCT_OUTPUT_VALID_DELAY_NS = 10;
  localparam int MCT_OUTPUT_VALID_CYCLES  =
    ((MCT_OUTPUT_VALID_DELAY_NS * 1000) / MCT_CLK_PERIOD_PS) < 1 ? 1 :
    ((MCT_OUTPUT_VALID_DELAY_NS * 1000) / MCT_CLK_PERIOD_PS);

  // reference mode select values
  localparam logic MCT_VREF_HALF_SEL = 1'h1;

endpackage : mct_pkg

// ---- tb/mct_properties.sv ----
// checker of the connectivity test outputs
`timescale 1ns/1ps
module mct_properties #(parameter int WIDTH = 16)(
  input wire logic i_clk, i_rst_n, i_test_enable_pin, i_cs_n, i_reset_pin_n,
  input wire logic [13:0] i_addr,
  input wire logic i_a10_ap, i_a12_bc, i_we_n_a14, i_cas_n_a15, i_ras_n_a16,
  input wire logic [1:0] i_ba, i_bg,
  input wire logic i_act_n, i_cke, i_odt, i_par, i_ck_t, i_ck_c, i_alert_n,
  input wire logic i_dm_lower_n, i_dm_upper_n,
  input wire logic [WIDTH-1:0] o_dq, o_dq_oe,
  input wire logic [1:0] o_dqs_t, o_dqs_c, o_dqs_oe,
  input wire logic o_continuity_check_mode, o_vref_half_sel, o_refresh_block
);
  logic [3:0] age;
  wire logic live = (age == 4'h8);
  wire logic on = i_test_enable_pin & !i_cs_n;
  wire logic [34:0] pins = {i_test_enable_pin, i_cs_n, i_reset_pin_n, i_addr, i_a10_ap, i_a12_bc,
    i_we_n_a14, i_cas_n_a15, i_ras_n_a16, i_ba, i_bg, i_act_n, i_cke, i_odt, i_par, i_ck_t,
    i_ck_c, i_alert_n, i_dm_lower_n, i_dm_upper_n};
  wire logic [9:0] m = {i_bg[0] ^ i_addr[3] ^ (i_reset_pin_n & i_test_enable_pin),
    i_we_n_a14 ^ i_a12_bc ^ i_ba[0], i_dm_upper_n ^ i_dm_lower_n ^ i_ck_t,
    i_act_n ^ i_addr[4] ^ i_ba[1], i_cke ^ i_ras_n_a16 ^ i_a10_ap,
    i_ck_c ^ i_odt ^ i_cas_n_a15, i_addr[0] ^ i_addr[7] ^ i_addr[11],
    i_addr[2] ^ i_addr[5] ^ i_addr[13], i_addr[8] ^ i_alert_n ^ i_addr[9],
    i_addr[1] ^ i_addr[6] ^ i_par};
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      age <= 4'h0;
    else if (!live)
      age <= age + 4'h1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  dq_value_a: assert property (live && $past(pins, 4) == $past(pins, 5)
    |-> o_dq == {~$past(m[7:0], 5), $past(m[7:0], 5)}) else $error("dq wrong");
  dqs_true_a: assert property (live && $past(pins, 4) == $past(pins, 5)
    |-> o_dqs_t == $past(m[9:8], 5)) else $error("dqs_t wrong");
  dqs_comp_a: assert property (live |-> o_dqs_c == ~o_dqs_t)
    else $error("dqs_c wrong");
  dq_drive_a: assert property (live && $past(pins, 4) == $past(pins, 5)
    |-> o_dq_oe == {WIDTH{$past(on, 5)}}) else $error("dq_oe wrong");
  dqs_drive_a: assert property (live && $past(pins, 4) == $past(pins, 5)
    |-> o_dqs_oe == {2{$past(on, 5)}}) else $error("dqs_oe wrong");
  mode_follow_a: assert property (live && $past(pins, 4) == $past(pins, 5)
    |-> o_continuity_check_mode == $past(i_test_enable_pin, 5)) else $error("mode wrong");
  vref_half_a: assert property (live && $past(pins, 4) == $past(pins, 5)
    |-> o_vref_half_sel == $past(i_test_enable_pin, 5)) else $error("vref wrong");
  refresh_stop_a: assert property (live && $past(pins, 4) == $past(pins, 5)
    |-> o_refresh_block == $past(i_test_enable_pin, 5)) else $error("refresh block wrong");
  cover property (on ##1 !on);
  cover property ($rose(i_test_enable_pin));
  cover property (i_cs_n && i_test_enable_pin);
endmodule // mct_properties
bind mct_conn_test mct_properties #(.WIDTH(WIDTH)) u_chk (.*);

// ---- tb/mct_agent_model.sv ----
// board-side agent driving the test pattern pins
`timescale 1ns/1ps
module mct_agent_model (
  input  wire logic        i_clk,
  input  wire logic [31:0] i_pat,
  output logic      [31:0] o_pins,
  output logic             o_reset_pin_n
);
  always_ff @(posedge i_clk) o_pins <= i_pat;
  assign o_reset_pin_n = 1'h1;
endmodule // mct_agent_model

// ---- tb/memory_connectivity_test_logic_tb_top.sv ----
// testbench for the connectivity test logic
`timescale 1ns/1ps
module memory_connectivity_test_logic_tb_top;
  localparam logic [127:0] MAP = 128'h77147045_6f968548_852f3f11_30269203;
  logic clk = 1'h0, rst_n = 1'h0, te = 1'h0, cs_n = 1'h1, rp_n;
  logic [31:0] pat = 32'h0, p;
  logic [15:0] dq, oe;
  logic [1:0] dqs_t, dqs_c, soe;
  logic mode, vref, rblk;
  int fail_count = 0, compares = 0;
  always #5 clk = ~clk;
  mct_agent_model agent (.i_clk(clk), .i_pat(pat), .o_pins(p), .o_reset_pin_n(rp_n));
  mct_conn_test dut (.i_clk(clk), .i_rst_n(rst_n), .i_test_enable_pin(te), .i_cs_n(cs_n),
    .i_reset_pin_n(rp_n), .i_addr(p[13:0]), .i_a10_ap(p[14]), .i_a12_bc(p[15]),
    .i_we_n_a14(p[16]), .i_cas_n_a15(p[17]), .i_ras_n_a16(p[18]), .i_ba(p[20:19]),
    .i_bg(p[22:21]), .i_act_n(p[23]), .i_cke(p[24]), .i_odt(p[25]), .i_par(p[26]),
    .i_ck_t(p[27]), .i_ck_c(p[28]), .i_alert_n(p[29]), .i_dm_lower_n(p[30]),
    .i_dm_upper_n(p[31]), .o_dq(dq), .o_dq_oe(oe), .o_dqs_t(dqs_t), .o_dqs_c(dqs_c),
    .o_dqs_oe(soe), .o_continuity_check_mode(mode), .o_vref_half_sel(vref),
    .o_refresh_block(rblk));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apply(input logic [31:0] v, input logic t, input logic c);
    logic [9:0] m;
    m = {t, 9'h0};
    for (int i = 0; i < 32; i++)
      if (v[i]) m = m ^ (10'h1 << MAP[4*i+:4]);
    @(posedge clk);
    pat <= v;
    te <= t;
    cs_n <= c;
    repeat (6) @(posedge clk);
    #1;
    chk("dq", {~m[7:0], m[7:0]}, dq);
    chk("dqs", {12'h0, ~m[9:8], m[9:8]}, {12'h0, dqs_c, dqs_t});
    chk("dq_oe", {16{t & ~c}}, oe);
    chk("flags", {11'h0, {2{t & ~c}}, t, t, t}, {11'h0, soe, mode, vref, rblk});
  endtask
  task automatic walk_ones();
    for (int i = 0; i < 32; i++)
      apply(32'h1 << i, 1'h1, 1'h0);
  endtask
  task automatic back_to_back();
    apply(32'hffffffff, 1'h1, 1'h0);
    apply(32'h0, 1'h1, 1'h0);
    apply(32'ha5a5a5a5, 1'h1, 1'h0);
  endtask
  task automatic deselect_and_exit();
    apply(32'h5a5a5a5a, 1'h1, 1'h1);
    apply(32'h0, 1'h0, 1'h0);
  endtask
  task automatic conclude();
    if (fail_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    apply(32'h01000000, 1'h1, 1'h1);
    walk_ones();
    back_to_back();
    deselect_and_exit();
    conclude();
  end
  initial
  begin
    #5000;
    fail_count++;
    conclude();
  end
endmodule // memory_connectivity_test_logic_tb_top
